// >>> common/ebs_map.vh
// offsets, fields, reset values and timing counts for the bring-up sequencer
// assumes the includer works on clk_sys at EBS_CLK_MHZ
`ifndef EBS_MAP_VH
`define EBS_MAP_VH
// ****************************************************
// timing
// ****************************************************
`define EBS_CLK_MHZ 200
`define EBS_SETTLE_NS 2000
`define EBS_SETTLE_CYC ((`EBS_SETTLE_NS*`EBS_CLK_MHZ+999)/1000)
`define EBS_PTP_WAIT_US 100
`define EBS_PTP_WAIT_CYC (`EBS_PTP_WAIT_US*`EBS_CLK_MHZ)
`define EBS_BUS_MHZ 100
`define EBS_MDIO_KHZ 2500
`define EBS_MDIO_DIV ((`EBS_BUS_MHZ*1000)/(2*`EBS_MDIO_KHZ)-1)
// ****************************************************
// apb registers of the sequencer
// ****************************************************
`define EBS_REG_CTRL 12'h000
`define EBS_REG_STATUS 12'h004
`define EBS_CTRL_BIST 0
`define EBS_CTRL_UPDATE 1
// ****************************************************
// management register map
// ****************************************************
`define EBS_MAC_FC_CFG 16'h040C
`define EBS_MAC_SPEED 16'h0410
`define EBS_MAC_MDIO_CFG 16'h0500
`define EBS_MAC_MDIO_CTRL 16'h0504
`define EBS_MAC_MDIO_WDATA 16'h0508
`define EBS_MAC_MDIO_RDATA 16'h050C
`define EBS_MAC_UCAST 16'h0700
`define EBS_MAC_AF_MODE 16'h0708
`define EBS_MAC_FILT 16'h0710
`define EBS_AVB_RTC_CTRL 16'h2000
`define EBS_AVB_PTP_CTRL 16'h2004
`define EBS_AVB_PTP_TXREQ 16'h2008
`define EBS_AVB_PTP_RXCNT 16'h200C
`define EBS_MDIO_EN 32'h00000040
`define EBS_MDIO_READY 7
`define EBS_OP_RD 2'h2
`define EBS_OP_WR 2'h1
`define EBS_AF_PROMISC 32'h80000000
`define EBS_FC_OFF 32'h00000000
`define EBS_RTC_START 32'h00000001
`define EBS_PTP_TXRX 32'h00000003
`define EBS_PTP_TX_ONE 32'h00000001
`define EBS_PTP_NEED 32'h00000002
// ****************************************************
// phy registers and values
// ****************************************************
`define EBS_PHY_ADDR 5'h07
`define EBS_PHY_BMCR 5'h00
`define EBS_PHY_BMSR 5'h01
`define EBS_PHY_ID 5'h02
`define EBS_PHY_ANAR 5'h04
`define EBS_PHY_GCTRL 5'h09
`define EBS_PHY_IFMODE 5'h14
`define EBS_BMCR_RST_AN 32'h00009200
`define EBS_AN_DONE 5
`define EBS_ANAR_BASE 32'h00000001
`define EBS_ANAR_10 32'h00000060
`define EBS_ANAR_100 32'h00000180
`define EBS_GCTRL_1000 32'h00000200
`define EBS_IF_ONLY 15
`define EBS_IF_MASK 32'h0000000F
`define EBS_IF_RGMII 32'h0000000B
`define EBS_ALL_ONES 16'hFFFF
// ****************************************************
// filter pattern, low byte first on the wire
// ****************************************************
`define EBS_FILT_V0 32'h040302DA
`define EBS_FILT_V1 32'h025A0605
`define EBS_FILT_V2 32'h06050403
`define EBS_FILT_MASK 32'hFFFFFFFF
`define EBS_UCAST_HI 32'h00000605
`endif

// >>> hw/ebs_seq.v
// bring-up sequencer: masters the mac management bus, apb slave for control
// assumes mgmt_ack/mgmt_rdata on clk_sys; pins synchronised here
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`include "ebs_map.vh"

// Summary of operation
// - settle, then enable mdio with divider
// - probe phy address seven by mdio read
// - all ones probe skips all mdio
// - write phy speed advertisement from speed
// - rgmii read-modify-write unless phy rgmii-only
// - reset phy and restart auto-negotiation
// - mac speed written after negotiation done
// - then write flow control disabled
// - filter bytes, promiscuous only with phy
// - no filter: unicast address, promiscuous
// - avb: start rtc, enable ptp tx/rx
// - idle; update request reruns from probe
// - serial command and response port
// - self-test sends two ptp, checks return
module ebs_seq #(
   parameter FRAME_FILTER = 1,
   parameter AVB_PRESENT = 1,
   parameter RGMII = 1,
   parameter [15:0] PTP_WAIT_CYC = `EBS_PTP_WAIT_CYC
) (
   input wire clk_sys,
   input wire reset_n,
   input wire [1:0] mac_speed,
   input wire update_speed,
   input wire serial_command,
   output reg serial_response,
   output reg mgmt_req,
   output reg mgmt_wr,
   output reg [15:0] mgmt_addr,
   output reg [31:0] mgmt_wdata,
   input wire mgmt_ack,
   input wire [31:0] mgmt_rdata,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr
);
   localparam integer SETTLE_I = `EBS_SETTLE_CYC;
   localparam integer MDIO_DIV_I = `EBS_MDIO_DIV;
   localparam [15:0] SETTLE = SETTLE_I[15:0];
   localparam [7:0] MDIO_DIV = MDIO_DIV_I[7:0];
   localparam [2:0] FILT_LAST = FRAME_FILTER ? 3'h5 : 3'h1;
   localparam [4:0] S_SETTLE = 5'h00, S_MDIO_EN = 5'h01,
      S_PROBE = 5'h02, S_ADV = 5'h03, S_ADV_G = 5'h04,
      S_IF_RD = 5'h05, S_IF_WR = 5'h06, S_PHY_RST = 5'h07,
      S_AN = 5'h08, S_SPEED = 5'h09, S_FLOW = 5'h0A,
      S_FILT = 5'h0B, S_FMODE = 5'h0C, S_RTC = 5'h0D,
      S_PTP_EN = 5'h0E, S_PTP_TX = 5'h0F, S_PTP_CHK = 5'h10,
      S_IDLE = 5'h11, S_SER = 5'h12;
   localparam [2:0] OP_IDLE = 3'h0, OP_WDATA = 3'h1, OP_CTRL = 3'h2,
      OP_POLL = 3'h3, OP_RDATA = 3'h4, OP_BUS = 3'h5;

   // ****************************************************
   // pin synchronisers
   // ****************************************************
   reg [1:0] spd_s1, spd_s2;
   reg upd_s1, upd_s2, upd_s3, cmd_s1, cmd_s2;
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         spd_s1 <= 2'h0;
         spd_s2 <= 2'h0;
         upd_s1 <= 1'b0;
         upd_s2 <= 1'b0;
         upd_s3 <= 1'b0;
         cmd_s1 <= 1'b0;
         cmd_s2 <= 1'b0;
      end else begin
         spd_s1 <= mac_speed;
         spd_s2 <= spd_s1;
         upd_s1 <= update_speed;
         upd_s2 <= upd_s1;
         upd_s3 <= upd_s2;
         cmd_s1 <= serial_command;
         cmd_s2 <= cmd_s1;
      end
   end

   // ****************************************************
   // helpers
   // ****************************************************
   function [31:0] mdio_ctrl;
      input [4:0] r;
      input rd;
      begin
         mdio_ctrl = {3'h0, `EBS_PHY_ADDR, 3'h0, r,
            rd ? `EBS_OP_RD : `EBS_OP_WR, 2'h0, 1'b1, 11'h000};
      end
   endfunction

   function [31:0] filt_word;
      input [2:0] i;
      begin
         case (i)
            3'h0: filt_word = `EBS_FILT_V0;
            3'h1: filt_word = `EBS_FILT_V1;
            3'h2: filt_word = `EBS_FILT_V2;
            default: filt_word = `EBS_FILT_MASK;
         endcase
      end
   endfunction

   reg [4:0] st;
   reg [2:0] op_st;
   reg issued, op_md, op_wr;
   reg [15:0] op_addr;
   reg [31:0] op_wdata, op_rdata;
   reg [2:0] idx;
   reg [15:0] cnt;
   reg [1:0] spd;
   reg phy_present, ptp_pass, ptp_fail, cfg_done;
   reg ctrl_bist, sw_update;
   reg ser_valid;
   reg [5:0] rx_cnt, tx_cnt;
   reg [48:0] rx_sr;
   reg [32:0] tx_sr;
   reg [15:0] next_addr;
   reg [31:0] next_wdata;
   reg next_wr;
   wire op_idle = (op_st == OP_IDLE);
   wire upd_edge = upd_s2 & ~upd_s3;
   wire upd_take = (st == S_IDLE) & op_idle & (upd_edge | sw_update);
   wire [31:0] anar = `EBS_ANAR_BASE |
      ((spd == 2'h0) ? `EBS_ANAR_10 : 32'h0) |
      ((spd == 2'h1) ? `EBS_ANAR_100 : 32'h0);

   // ****************************************************
   // access engine: address and data per phase
   // ****************************************************
   always @* begin
      next_addr = op_addr;
      next_wdata = op_wdata;
      next_wr = op_wr;
      case (op_st)
         OP_WDATA: begin
            next_addr = `EBS_MAC_MDIO_WDATA;
            next_wr = 1'b1;
         end
         OP_CTRL: begin
            next_addr = `EBS_MAC_MDIO_CTRL;
            next_wdata = mdio_ctrl(op_addr[4:0], ~op_wr);
            next_wr = 1'b1;
         end
         OP_POLL: begin
            next_addr = `EBS_MAC_MDIO_CTRL;
            next_wr = 1'b0;
         end
         OP_RDATA: begin
            next_addr = `EBS_MAC_MDIO_RDATA;
            next_wr = 1'b0;
         end
         default: begin
            next_addr = op_addr;
         end
      endcase
   end

   // launch one bus access or one mdio transaction
   task go;
      input md;
      input wr;
      input [15:0] a;
      input [31:0] d;
      begin
         op_md <= md;
         op_wr <= wr;
         op_addr <= a;
         op_wdata <= d;
         op_st <= md ? (wr ? OP_WDATA : OP_CTRL) : OP_BUS;
         issued <= 1'b1;
      end
   endtask

   // ****************************************************
   // sequencer, access engine and serial port
   // ****************************************************
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st <= S_SETTLE;
         op_st <= OP_IDLE;
         issued <= 1'b0;
         op_md <= 1'b0;
         op_wr <= 1'b0;
         op_addr <= 16'h0000;
         op_wdata <= 32'h00000000;
         op_rdata <= 32'h00000000;
         idx <= 3'h0;
         cnt <= SETTLE;
         spd <= 2'h0;
         phy_present <= 1'b0;
         ptp_pass <= 1'b0;
         ptp_fail <= 1'b0;
         cfg_done <= 1'b0;
         mgmt_req <= 1'b0;
         mgmt_wr <= 1'b0;
         mgmt_addr <= 16'h0000;
         mgmt_wdata <= 32'h00000000;
         ser_valid <= 1'b0;
         rx_cnt <= 6'h00;
         rx_sr <= 49'h0;
         tx_cnt <= 6'h00;
         tx_sr <= 33'h0;
         serial_response <= 1'b0;
      end else begin
         // one access outstanding; released on its ack
         if (!op_idle) begin
            if (!mgmt_req) begin
               mgmt_req <= 1'b1;
               mgmt_wr <= next_wr;
               mgmt_addr <= next_addr;
               mgmt_wdata <= next_wdata;
            end else if (mgmt_ack) begin
               mgmt_req <= 1'b0;
               case (op_st)
                  OP_WDATA: op_st <= OP_CTRL;
                  OP_CTRL: op_st <= OP_POLL;
                  OP_POLL: begin
                     // mdio done before anything else is issued
                     if (mgmt_rdata[`EBS_MDIO_READY])
                        op_st <= op_wr ? OP_IDLE : OP_RDATA;
                  end
                  default: begin
                     op_rdata <= mgmt_rdata;
                     op_st <= OP_IDLE;
                  end
               endcase
            end
         end else if (st == S_SETTLE) begin
            if (cnt == 16'h0000)
               st <= S_MDIO_EN;
            else
               cnt <= cnt - 16'h0001;
         end else if (st == S_IDLE) begin
            cfg_done <= 1'b1;
            if (upd_take) begin
               spd <= spd_s2;
               st <= S_PROBE;
               cfg_done <= 1'b0;
            end else if (ser_valid) begin
               st <= S_SER;
            end
         end else if (!issued) begin
            case (st)
               S_MDIO_EN: go(1'b0, 1'b1, `EBS_MAC_MDIO_CFG,
                  `EBS_MDIO_EN | {24'h0, MDIO_DIV});
               S_PROBE: go(1'b1, 1'b0, {11'h0, `EBS_PHY_ID},
                  32'h0);
               S_ADV: go(1'b1, 1'b1, {11'h0, `EBS_PHY_ANAR},
                  anar);
               S_ADV_G: go(1'b1, 1'b1, {11'h0, `EBS_PHY_GCTRL},
                  (spd == 2'h2) ? `EBS_GCTRL_1000 : 32'h0);
               S_IF_RD: go(1'b1, 1'b0, {11'h0, `EBS_PHY_IFMODE},
                  32'h0);
               S_IF_WR: go(1'b1, 1'b1, {11'h0, `EBS_PHY_IFMODE},
                  (op_rdata & ~`EBS_IF_MASK) | `EBS_IF_RGMII);
               S_PHY_RST: go(1'b1, 1'b1, {11'h0, `EBS_PHY_BMCR},
                  `EBS_BMCR_RST_AN);
               S_AN: go(1'b1, 1'b0, {11'h0, `EBS_PHY_BMSR},
                  32'h0);
               S_SPEED: go(1'b0, 1'b1, `EBS_MAC_SPEED,
                  {spd, 30'h0});
               S_FLOW: go(1'b0, 1'b1, `EBS_MAC_FC_CFG,
                  `EBS_FC_OFF);
               S_FILT: begin
                  if (FRAME_FILTER)
                     go(1'b0, 1'b1, `EBS_MAC_FILT + {11'h0, idx, 2'h0},
                        filt_word(idx));
                  else
                     go(1'b0, 1'b1, `EBS_MAC_UCAST + {11'h0, idx, 2'h0},
                        idx[0] ? `EBS_UCAST_HI : `EBS_FILT_V0);
               end
               S_FMODE: go(1'b0, 1'b1, `EBS_MAC_AF_MODE,
                  (!FRAME_FILTER || phy_present) ?
                  `EBS_AF_PROMISC : 32'h0);
               S_RTC: go(1'b0, 1'b1, `EBS_AVB_RTC_CTRL,
                  `EBS_RTC_START);
               S_PTP_EN: go(1'b0, 1'b1, `EBS_AVB_PTP_CTRL,
                  `EBS_PTP_TXRX);
               S_PTP_TX: go(1'b0, 1'b1, `EBS_AVB_PTP_TXREQ,
                  `EBS_PTP_TX_ONE);
               S_PTP_CHK: go(1'b0, 1'b0, `EBS_AVB_PTP_RXCNT,
                  32'h0);
               S_SER: go(1'b0, rx_sr[48], rx_sr[47:32],
                  rx_sr[31:0]);
               default: st <= S_IDLE;
            endcase
         end else begin
            issued <= 1'b0;
            case (st)
               S_MDIO_EN: begin
                  spd <= spd_s2;
                  st <= S_PROBE;
               end
               S_PROBE: begin
                  phy_present <= (op_rdata[15:0] != `EBS_ALL_ONES);
                  if (op_rdata[15:0] == `EBS_ALL_ONES)
                     st <= S_SPEED;
                  else
                     st <= S_ADV;
               end
               S_ADV: st <= S_ADV_G;
               S_ADV_G: st <= RGMII ? S_IF_RD : S_PHY_RST;
               S_IF_RD: st <= op_rdata[`EBS_IF_ONLY] ?
                  S_PHY_RST : S_IF_WR;
               S_IF_WR: st <= S_PHY_RST;
               S_PHY_RST: st <= S_AN;
               S_AN: begin
                  if (op_rdata[`EBS_AN_DONE])
                     st <= S_SPEED;
               end
               S_SPEED: st <= S_FLOW;
               S_FLOW: begin
                  idx <= 3'h0;
                  st <= S_FILT;
               end
               S_FILT: begin
                  idx <= idx + 3'h1;
                  if (idx == FILT_LAST)
                     st <= S_FMODE;
               end
               S_FMODE: st <= AVB_PRESENT ? S_RTC : S_IDLE;
               S_RTC: st <= S_PTP_EN;
               S_PTP_EN: begin
                  idx <= 3'h0;
                  ptp_pass <= 1'b0;
                  ptp_fail <= 1'b0;
                  cnt <= PTP_WAIT_CYC;
                  st <= ctrl_bist ? S_PTP_TX : S_IDLE;
               end
               S_PTP_TX: begin
                  idx <= idx + 3'h1;
                  if (idx == 3'h1)
                     st <= S_PTP_CHK;
               end
               S_PTP_CHK: begin
                  if (op_rdata >= `EBS_PTP_NEED) begin
                     ptp_pass <= 1'b1;
                     st <= S_IDLE;
                  end else if (cnt == 16'h0000) begin
                     ptp_fail <= 1'b1;
                     st <= S_IDLE;
                  end else begin
                     cnt <= cnt - 16'h0001;
                  end
               end
               S_SER: begin
                  ser_valid <= 1'b0;
                  tx_sr <= {1'b1, op_rdata};
                  tx_cnt <= 6'h21;
                  st <= S_IDLE;
               end
               default: st <= S_IDLE;
            endcase
         end
         // serial command: start bit, write flag, address, data
         if (rx_cnt == 6'h00) begin
            if (cmd_s2 & ~ser_valid & ~(st == S_SER))
               rx_cnt <= 6'h31;
         end else begin
            rx_sr <= {rx_sr[47:0], cmd_s2};
            rx_cnt <= rx_cnt - 6'h01;
            if (rx_cnt == 6'h01)
               ser_valid <= 1'b1;
         end
         // serial response: start bit then 32 bits, msb first
         if (tx_cnt != 6'h00) begin
            serial_response <= tx_sr[32];
            tx_sr <= {tx_sr[31:0], 1'b0};
            tx_cnt <= tx_cnt - 6'h01;
         end else begin
            serial_response <= 1'b0;
         end
      end
   end

   // ****************************************************
   // apb slave
   // ****************************************************
   wire apb_hit_c = (paddr == `EBS_REG_CTRL);
   wire apb_hit_s = (paddr == `EBS_REG_STATUS);
   wire apb_fire = psel & penable & pready;
   wire [31:0] status = {11'h000, st, 6'h00, spd, 4'h0,
      ptp_fail, ptp_pass, phy_present, cfg_done};
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         ctrl_bist <= 1'b0;
         sw_update <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         if (psel & penable & ~pready) begin
            prdata <= apb_hit_c ? {30'h0, sw_update, ctrl_bist} :
               apb_hit_s ? status : 32'h00000000;
            pslverr <= ~(apb_hit_c | apb_hit_s);
         end
         if (apb_fire & pwrite & apb_hit_c)
            ctrl_bist <= pwdata[`EBS_CTRL_BIST];
         // a new request wins over the one being taken
         sw_update <= (apb_fire & pwrite & apb_hit_c &
            pwdata[`EBS_CTRL_UPDATE]) | (sw_update & ~upd_take);
      end
   end
endmodule // ebs_seq

// >>> tb/ebs_mgmt_model.sv
// mac management registers with a phy behind mdio
// assumes requests held until ack; lat sets the ack wait
`timescale 1ns/1ps
`include "ebs_map.vh"
module ebs_mgmt_model (
   input wire clk_sys,
   input wire reset_n,
   input wire [3:0] lat,
   input wire phy_on,
   input wire ptp_drop,
   input wire mgmt_req,
   input wire mgmt_wr,
   input wire [15:0] mgmt_addr,
   input wire [31:0] mgmt_wdata,
   output reg mgmt_ack,
   output reg [31:0] mgmt_rdata
);
   logic [47:0] log [$];
   logic [31:0] mem [logic [15:0]];
   logic [15:0] phy [0:31];
   logic [4:0] r;
   int wt;
   int an;
   initial begin
      foreach (phy[i])
         phy[i] = 16'h0000;
      // arbitrary id; interface field open to other modes
      phy[`EBS_PHY_ID] = 16'h0A5C;
      phy[`EBS_PHY_IFMODE] = 16'h1230;
   end
   // log: plain writes, E0rr phy writes, D0rr phy reads
   task wr_reg;
      r = mgmt_wdata[20:16];
      if (mgmt_addr != `EBS_MAC_MDIO_CTRL) begin
         if (mgmt_addr != `EBS_MAC_MDIO_WDATA)
            log.push_back({mgmt_addr, mgmt_wdata});
         mem[mgmt_addr] = mgmt_wdata;
         if (mgmt_addr == `EBS_AVB_PTP_CTRL)
            mem[`EBS_AVB_PTP_RXCNT] = 32'h0;
         if (mgmt_addr == `EBS_AVB_PTP_TXREQ && !ptp_drop)
            mem[`EBS_AVB_PTP_RXCNT]++;
      end else if (mgmt_wdata[15:14] == `EBS_OP_WR) begin
         log.push_back({16'hE000 | r, mem[`EBS_MAC_MDIO_WDATA]});
         phy[r] = mem[`EBS_MAC_MDIO_WDATA][15:0];
         if (r == `EBS_PHY_BMCR)
            an = 2;
      end else begin
         log.push_back({16'hD000 | r, 32'h0});
         an = an - (r == `EBS_PHY_BMSR);
         mem[`EBS_MAC_MDIO_RDATA] = !phy_on
            || mgmt_wdata[28:24] != `EBS_PHY_ADDR ? 32'hFFFF
            : r != `EBS_PHY_BMSR ? phy[r] : an > 0 ? 32'h0 : 32'h20;
      end
   endtask
   // idle read data toggles so stale values never match
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mgmt_ack <= 1'b0;
         mgmt_rdata <= 32'h0;
         wt = 0;
         an = 0;
      end else if (mgmt_req && !mgmt_ack && wt >= lat) begin
         wt = 0;
         mgmt_ack <= 1'b1;
         mgmt_rdata <= ~mgmt_rdata;
         if (mgmt_wr)
            wr_reg();
         else if (mgmt_addr == `EBS_MAC_MDIO_CTRL)
            mgmt_rdata <= 32'h80;
         else
            mgmt_rdata <= mem.exists(mgmt_addr) ? mem[mgmt_addr] : 32'h0;
      end else begin
         wt = mgmt_req && !mgmt_ack ? wt + 1 : 0;
         mgmt_ack <= 1'b0;
         mgmt_rdata <= ~mgmt_rdata;
      end
   end
endmodule // ebs_mgmt_model

// >>> tb/ebs_seq_properties.sv
// checker on the sequencer top ports
// assumes one clock domain; bound onto ebs_seq below
`timescale 1ns/1ps
`include "ebs_map.vh"
module ebs_seq_props (
   input wire clk_sys,
   input wire reset_n,
   input wire mgmt_req,
   input wire mgmt_wr,
   input wire [15:0] mgmt_addr,
   input wire [31:0] mgmt_wdata,
   input wire mgmt_ack,
   input wire [31:0] mgmt_rdata,
   input wire psel,
   input wire penable,
   input wire pready
);
   // ****************
   // helper state
   // ****************
   reg [8:0] cnt;
   reg seen;
   reg busy;
   reg rtc;
   wire ctl = mgmt_addr == `EBS_MAC_MDIO_CTRL;
   wire done = mgmt_req && mgmt_ack;
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 9'h000;
         seen <= 1'b0;
         busy <= 1'b0;
         rtc <= 1'b0;
      end else begin
         if (cnt != 9'h1FF)
            cnt <= cnt + 9'h001;
         if (mgmt_req)
            seen <= 1'b1;
         // mdio busy from command until ready seen
         if (done && ctl)
            busy <= mgmt_wr || !mgmt_rdata[`EBS_MDIO_READY];
         if (done && mgmt_wr && mgmt_addr == `EBS_AVB_RTC_CTRL)
            rtc <= 1'b1;
      end
   end
   // ****************
   // properties
   // ****************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   property p_hold;
      mgmt_req && !mgmt_ack |=> mgmt_req && $stable(mgmt_addr)
         && $stable(mgmt_wr) && $stable(mgmt_wdata);
   endproperty
   a_hold: assert property (p_hold) else $error("request moved");
   property p_drop;
      done |=> !mgmt_req;
   endproperty
   a_drop: assert property (p_drop) else $error("request kept");
   property p_settle;
      mgmt_req |-> cnt >= 9'h18F;
   endproperty
   a_settle: assert property (p_settle) else $error("early access");
   property p_first;
      mgmt_req && !seen |-> mgmt_wr && mgmt_addr == `EBS_MAC_MDIO_CFG
         && mgmt_wdata == (`EBS_MDIO_EN | `EBS_MDIO_DIV);
   endproperty
   a_first: assert property (p_first) else $error("bad first");
   property p_phy_address;
      mgmt_req && mgmt_wr && ctl |-> mgmt_wdata[28:24] == `EBS_PHY_ADDR
         && mgmt_wdata[11];
   endproperty
   a_phy_address: assert property (p_phy_address) else $error("bad phy addr");
   property p_one_mdio;
      mgmt_req && mgmt_wr && ctl |-> !busy;
   endproperty
   a_one_mdio: assert property (p_one_mdio) else $error("mdio overlap");
   property p_ptp;
      mgmt_req && mgmt_wr && mgmt_addr == `EBS_AVB_PTP_CTRL |-> rtc;
   endproperty
   a_ptp: assert property (p_ptp) else $error("ptp before rtc");
   property p_wait;
      $rose(penable) && psel |-> !pready ##1 pready ##1 !pready;
   endproperty
   a_wait: assert property (p_wait) else $error("apb wait wrong");
endmodule // ebs_seq_props
bind ebs_seq ebs_seq_props i_props (.clk_sys, .reset_n, .mgmt_req,
   .mgmt_wr, .mgmt_addr, .mgmt_wdata, .mgmt_ack, .mgmt_rdata, .psel,
   .penable, .pready);

// >>> tb/ebs_seq_tb.sv
// self-checking bench for the bring-up sequencer
// assumes the management model and the bound checker
`timescale 1ns/1ps
`include "ebs_map.vh"
module ebs_seq_tb;
   reg clk_sys = 1'b0, reset_n = 1'b0;
   reg [1:0] mac_speed = 2'h2;
   reg update_speed = 1'b0, serial_command = 1'b0;
   reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   reg [3:0] lat = 4'h0;
   reg phy_on = 1'b1, ptp_drop = 1'b0;
   wire serial_response, mgmt_req, mgmt_wr, mgmt_ack, pready, pslverr;
   wire [15:0] mgmt_addr;
   wire [31:0] mgmt_wdata, mgmt_rdata, prdata;
   int err_total = 0;
   int n_checks = 0;
   logic [47:0] exp_q [$];
   logic [31:0] rd;
   logic err;
   ebs_seq #(.PTP_WAIT_CYC(16'h0032)) i_dut (.clk_sys, .reset_n,
      .mac_speed, .update_speed, .serial_command, .serial_response,
      .mgmt_req, .mgmt_wr, .mgmt_addr, .mgmt_wdata, .mgmt_ack, .mgmt_rdata,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   ebs_mgmt_model i_mod (.clk_sys, .reset_n, .lat, .phy_on, .ptp_drop,
      .mgmt_req, .mgmt_wr, .mgmt_addr, .mgmt_wdata, .mgmt_ack, .mgmt_rdata);
   // second build: no filter, no avb, no rgmii
   wire nf_req, nf_wr, nf_ack;
   wire [15:0] nf_addr;
   wire [31:0] nf_wdata, nf_rdata;
   ebs_seq #(.FRAME_FILTER(0), .AVB_PRESENT(0), .RGMII(0)) i_dut_nf (
      .clk_sys, .reset_n, .mac_speed, .update_speed(1'b0),
      .serial_command(1'b0), .serial_response(), .mgmt_req(nf_req),
      .mgmt_wr(nf_wr), .mgmt_addr(nf_addr), .mgmt_wdata(nf_wdata),
      .mgmt_ack(nf_ack), .mgmt_rdata(nf_rdata), .psel(1'b0),
      .penable(1'b0), .pwrite(1'b0), .paddr(12'h000), .pwdata(32'h0),
      .prdata(), .pready(), .pslverr());
   ebs_mgmt_model i_mod_nf (.clk_sys, .reset_n, .lat(4'h0), .phy_on,
      .ptp_drop(1'b0), .mgmt_req(nf_req), .mgmt_wr(nf_wr),
      .mgmt_addr(nf_addr), .mgmt_wdata(nf_wdata), .mgmt_ack(nf_ack),
      .mgmt_rdata(nf_rdata));
   initial forever #2.5 clk_sys = ~clk_sys;
   // ****************
   // tasks
   // ****************
   task chk(input logic [47:0] got, input logic [47:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task ex(input logic [15:0] a, input logic [31:0] d);
      exp_q.push_back({a, d});
   endtask
   // expected log of one run, then compare once idle
   task run(input bit ph, input bit bist, input bit first,
      input logic [1:0] s, input logic [31:0] st);
      exp_q = {};
      if (first)
         ex(`EBS_MAC_MDIO_CFG, `EBS_MDIO_EN | `EBS_MDIO_DIV);
      ex(16'hD002, 0);
      if (ph) begin
         ex(16'hE004, `EBS_ANAR_BASE | (s == 2'h0 ? `EBS_ANAR_10
            : s == 2'h1 ? `EBS_ANAR_100 : 0));
         ex(16'hE009, s == 2'h2 ? `EBS_GCTRL_1000 : 0);
         ex(16'hD014, 0);
         ex(16'hE014, 32'h123B);
         ex(16'hE000, `EBS_BMCR_RST_AN);
         ex(16'hD001, 0);
         ex(16'hD001, 0);
      end
      ex(`EBS_MAC_SPEED, {s, 30'h0});
      ex(`EBS_MAC_FC_CFG, `EBS_FC_OFF);
      for (int i = 0; i < 6; i++)
         ex(`EBS_MAC_FILT + 4 * i, i == 0 ? `EBS_FILT_V0 : i == 1 ?
            `EBS_FILT_V1 : i == 2 ? `EBS_FILT_V2 : `EBS_FILT_MASK);
      ex(`EBS_MAC_AF_MODE, ph ? `EBS_AF_PROMISC : 0);
      ex(`EBS_AVB_RTC_CTRL, `EBS_RTC_START);
      ex(`EBS_AVB_PTP_CTRL, `EBS_PTP_TXRX);
      for (int i = 0; i < 2 * bist; i++)
         ex(`EBS_AVB_PTP_TXREQ, `EBS_PTP_TX_ONE);
      while (i_mod.log.size() < exp_q.size())
         @(posedge clk_sys);
      do apb(1'b0, `EBS_REG_STATUS, 0); while (rd[0] !== 1'b1);
      chk(i_mod.log.size(), exp_q.size());
      foreach (exp_q[i])
         chk(i_mod.log[i], exp_q[i]);
      chk(rd & 32'h30F, st);
      i_mod.log.delete();
   endtask
   task ser(input logic w, input logic [15:0] a, input logic [31:0] d);
      logic [49:0] f;
      f = {1'b1, w, a, d};
      for (int i = 49; i >= 0; i--) begin
         @(posedge clk_sys);
         serial_command <= f[i];
      end
      @(posedge clk_sys);
      serial_command <= 1'b0;
      while (serial_response !== 1'b1)
         @(posedge clk_sys);
      for (int i = 0; i < 32; i++) begin
         @(posedge clk_sys);
         rd = {rd[30:0], serial_response};
      end
   endtask
   task results;
      if (err_total == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ****************
   // tests
   // ****************
   initial begin
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      apb(1'b0, `EBS_REG_CTRL, 0);
      chk(rd, 0);
      apb(1'b1, 12'h008, 32'hFFFFFFFF);
      chk({err, rd}, {1'b1, 32'h0});
      run(1, 0, 1, 2'h2, 32'h203);
      chk(i_mod_nf.log.size(), 12);
      chk(i_mod_nf.log[9], {`EBS_MAC_UCAST, `EBS_FILT_V0});
      chk(i_mod_nf.log[11], {`EBS_MAC_AF_MODE, `EBS_AF_PROMISC});
      lat <= 4'h5;
      mac_speed <= 2'h0;
      update_speed <= 1'b1;
      repeat (4) @(posedge clk_sys);
      update_speed <= 1'b0;
      run(1, 0, 0, 2'h0, 32'h003);
      phy_on <= 1'b0;
      mac_speed <= 2'h1;
      apb(1'b1, `EBS_REG_CTRL, 32'h2);
      run(0, 0, 0, 2'h1, 32'h101);
      apb(1'b1, `EBS_REG_CTRL, 32'h3);
      run(0, 1, 0, 2'h1, 32'h105);
      ptp_drop <= 1'b1;
      apb(1'b1, `EBS_REG_CTRL, 32'h3);
      run(0, 1, 0, 2'h1, 32'h109);
      apb(1'b0, `EBS_REG_CTRL, 0);
      chk(rd, 1);
      ser(1'b0, `EBS_MAC_SPEED, 0);
      chk(rd, 32'h40000000);
      ser(1'b1, `EBS_MAC_AF_MODE, 32'h5A5A0000);
      chk(i_mod.log[0], {`EBS_MAC_AF_MODE, 32'h5A5A0000});
      results();
   end
   // whole run is a few thousand cycles
   initial begin
      #300000;
      err_total++;
      results();
   end
endmodule // ebs_seq_tb
